/* File: hw/mr0_decode.sv */
`timescale 1ns/100ps
module mr0_decode (
	input logic [mrs_pkg::ADDR_W-1:0] word,
	output mrs_pkg::mr0_status_type status
);
	import mrs_pkg::*;

	// ----------------------------------------
	// cas latency lookup
	// ----------------------------------------
	function automatic logic [5:0] cl_lookup(input logic [4:0] code);
		logic [5:0] v;
		v = 6'h00;
		unique case (code)
			5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07: v = 6'h09 + {3'h0, code[2:0]};
			5'h08: v = 6'h12;
			5'h09: v = 6'h14;
			5'h0A: v = 6'h16;
			5'h0B: v = 6'h18;
			5'h0C: v = 6'h17;
			5'h0D: v = 6'h11;
			5'h0E: v = 6'h13;
			5'h0F: v = 6'h15;
			5'h10: v = 6'h19;
			5'h11: v = 6'h1A;
			5'h12: v = 6'h1B;
			5'h13: v = 6'h1C;
			5'h15: v = 6'h1E;
			5'h17: v = 6'h20;
			default: v = 6'h00;
		endcase
		return v;
	endfunction : cl_lookup

	wire [3:0] wr_code = {word[WR_MSB_BIT], word[WR_LSB+2:WR_LSB]};
	wire [4:0] cl_code = {word[CL_B4], word[CL_B1+2:CL_B1], word[CL_B0]};
	wire wr_bad = wr_code > WR_MAX_CODE;
	wire [5:0] cl_val = cl_lookup(cl_code);
	wire bl_bad = word[BL_LSB+1:BL_LSB] == BL_RSVD;

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	// recovery steps of two, precharge of one
	assign status.write_recovery = wr_bad ? 5'h00 : WR_BASE + {wr_code, 1'b0};
	assign status.read_to_precharge = wr_bad ? 4'h0 : RTP_BASE + wr_code;
	assign status.cas_latency = cl_val;
	assign status.interleave = word[BT_BIT];
	assign status.burst_mode = word[BL_LSB+1:BL_LSB];
	assign status.dll_reset = word[DLL_RST_BIT];
	assign status.test_mode_select = word[TM_BIT];
	assign status.reserved_field = wr_bad | bl_bad | (cl_val == 6'h00);

endmodule : mr0_decode

/* File: hw/mrs_ctrl.sv */
`timescale 1ns/100ps
// Contract
// - seven registers, written only by MRS
// - program all registers after power-up, reset
// - every MRS drives all address fields
// - MRS only when idle, CKE high
// - tMRD between successive MRS commands
// - exempt settings wait for function update
// - tMOD before any non-MRS command
// - long updates follow their own procedure
// - ODT low before termination-affecting MRS
// - no ODT hold when termination unchanged
// - ODT stays low until tMOD expires
// - BG1 and A17 driven zero
// - never program a reserved code; only MR0 codes and select 7 are refused
// - recovery code at least the minimum
module mrs_ctrl #(
	parameter int TMRD_NCK = mrs_pkg::TMRD_NCK,
	parameter int TMOD_NCK = mrs_pkg::TMOD_NCK,
	parameter int ODT_OFF_LAT = mrs_pkg::ODT_OFF_LAT,
	parameter int MIN_WR = mrs_pkg::MIN_WRITE_RECOVERY
) (
	input logic clk,
	input logic rst_n,
	input logic req_valid,
	input mrs_pkg::mrs_req_type req,
	output logic req_ready,
	output logic req_err,
	input logic cmd_valid,
	input mrs_pkg::ca_bus_type cmd,
	output logic cmd_ready,
	input logic idle_ok,
	input logic odt_want,
	input logic func_done,
	output logic busy,
	output mrs_pkg::mr0_status_type mr0_status,
	output logic ck_t,
	output logic ck_c,
	output logic cke,
	output logic odt,
	output logic cs_n,
	output mrs_pkg::ca_bus_type ca
);
	import mrs_pkg::*;

	localparam logic [CNT_W-1:0] MRD_LOAD = CNT_W'(TMRD_NCK - 1);
	localparam logic [CNT_W-1:0] MOD_LOAD = CNT_W'(TMOD_NCK - 1);
	localparam logic [CNT_W-1:0] ODT_HOLD = CNT_W'(ODT_OFF_LAT + 1);
	localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

	function automatic logic [CNT_W-1:0] dec_sat(input logic [CNT_W-1:0] v);
		return (v == '0) ? v : v - 1'b1;
	endfunction : dec_sat

	function automatic logic [CNT_W-1:0] inc_sat(input logic [CNT_W-1:0] v);
		return (v == CNT_MAX) ? v : v + 1'b1;
	endfunction : inc_sat

	// ----------------------------------------
	// state
	// ----------------------------------------
	state_type st_q, st_d;
	mrs_req_type req_q, req_d;
	ca_bus_type ca_q, ca_d;
	logic ck_t_q, ck_c_q;
	logic cke_q, cke_up_q;
	logic odt_q, odt_d, odt_keep_q, odt_keep_d;
	logic cs_n_q, cs_n_d;
	logic req_err_q;
	logic [CNT_W-1:0] mrd_cnt_q, mrd_cnt_d, mod_cnt_q, mod_cnt_d;
	logic [CNT_W-1:0] odt_low_q, odt_low_d;
	logic [ADDR_W-1:0] mr0_q, mr0_d;
	mr0_status_type req_status;

	// ----------------------------------------
	// request checks
	// ----------------------------------------
	mr0_decode u_req_dec (
		.word(req.addr),
		.status(req_status)
	);

	mr0_decode u_cur_dec (
		.word(mr0_q),
		.status(mr0_status)
	);

	// outputs change when ck falls, device samples on rise
	wire tick = ck_t_q;
	wire in_idle = st_q == ST_IDLE;
	wire in_hold = st_q == ST_HOLD;
	wire sel_mr0 = req.sel == SEL_MR0;
	wire wr_short = req_status.write_recovery < 5'(MIN_WR);
	wire req_bad = (req.sel == SEL_RSVD) | (sel_mr0 & (req_status.reserved_field | wr_short));
	wire take_req = req_ready & req_valid;
	wire take_ok = take_req & ~req_bad;
	wire mrd_ok = mrd_cnt_q == '0;
	wire mod_ok = mod_cnt_q == '0;
	wire odt_ok = ~req_q.odt_change | (odt_low_q >= ODT_HOLD);
	wire fire_mrs = tick & in_hold & idle_ok & cke_up_q & mrd_ok & odt_ok;
	wire fire_cmd = cmd_ready & cmd_valid;
	// odt forced low around the write
	// kept low until tmod runs out
	wire odt_block = odt_keep_q | (in_hold & req_q.odt_change);

	assign req_ready = tick & in_idle;
	assign cmd_ready = tick & in_idle & ~req_valid & mod_ok & cke_up_q;

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE: begin
				if (take_ok) begin
					st_d = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (fire_mrs) begin
					// long updates hand over to user
					st_d = req_q.long_update ? ST_WAITFN : ST_IDLE;
				end
			end
			ST_WAITFN: begin
				if (func_done) begin
					st_d = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	assign req_d = take_ok ? req : req_q;
	assign mrd_cnt_d = fire_mrs ? MRD_LOAD : (tick ? dec_sat(mrd_cnt_q) : mrd_cnt_q);
	assign mod_cnt_d = fire_mrs ? MOD_LOAD : (tick ? dec_sat(mod_cnt_q) : mod_cnt_q);
	assign odt_keep_d = (fire_mrs & req_q.odt_change) | (odt_keep_q & ~(tick & mod_ok));
	assign odt_d = tick ? (odt_want & ~odt_block & cke_up_q) : odt_q;
	assign odt_low_d = tick ? (odt_d ? '0 : inc_sat(odt_low_q)) : odt_low_q;
	assign cs_n_d = tick ? ~(fire_mrs | fire_cmd) : cs_n_q;

	// ----------------------------------------
	// command word
	// ----------------------------------------
	ca_bus_type mrs_word;
	assign mrs_word.act_n = 1'b1;
	assign mrs_word.ras_n = 1'b0;
	assign mrs_word.cas_n = 1'b0;
	assign mrs_word.we_n = 1'b0;
	// reserved bank-group and address bits zero
	assign mrs_word.bg = {1'b0, req_q.sel[2]};
	assign mrs_word.ba = req_q.sel[1:0];
	assign mrs_word.addr = {1'b0, req_q.addr[ADDR_W-2:0]};

	assign ca_d = fire_mrs ? mrs_word : (fire_cmd ? cmd : ca_q);
	assign mr0_d = (fire_mrs & (req_q.sel == SEL_MR0)) ? mrs_word.addr : mr0_q;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ck_t_q <= 1'b0;
			ck_c_q <= 1'b1;
			cke_q <= 1'b0;
			cke_up_q <= 1'b0;
		end else begin
			ck_t_q <= ~ck_t_q;
			ck_c_q <= ck_t_q;
			cke_q <= cke_q | tick;
			cke_up_q <= cke_up_q | (tick & cke_q);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= ST_IDLE;
			req_q <= '0;
			req_err_q <= 1'b0;
			mr0_q <= '0;
		end else begin
			st_q <= st_d;
			req_q <= req_d;
			req_err_q <= take_req & req_bad;
			mr0_q <= mr0_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mrd_cnt_q <= '0;
			mod_cnt_q <= '0;
			odt_keep_q <= 1'b0;
			odt_q <= 1'b0;
			odt_low_q <= '0;
		end else begin
			mrd_cnt_q <= mrd_cnt_d;
			mod_cnt_q <= mod_cnt_d;
			odt_keep_q <= odt_keep_d;
			odt_q <= odt_d;
			odt_low_q <= odt_low_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_n_q <= 1'b1;
			ca_q <= '{act_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
		end else begin
			cs_n_q <= cs_n_d;
			ca_q <= ca_d;
		end
	end

	assign ck_t = ck_t_q;
	assign ck_c = ck_c_q;
	assign cke = cke_q;
	assign odt = odt_q;
	assign cs_n = cs_n_q;
	assign ca = ca_q;
	assign req_err = req_err_q;
	assign busy = ~in_idle | ~mod_ok;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	localparam int MRD_CLK = TMRD_NCK * CK_DIV;
	localparam int MOD_CLK = TMOD_NCK * CK_DIV;
	logic [15:0] since_mrs_q;
	logic seen_mrs_q;
	logic cs_prev_q;
	wire mrs_on_pins = ~cs_n_q & ca_q.act_n & ~ca_q.ras_n & ~ca_q.cas_n & ~ca_q.we_n;
	wire cs_fell = cs_prev_q & ~cs_n_q;
	wire mrs_start = mrs_on_pins & ~ck_t_q & cs_fell;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			since_mrs_q <= '0;
			seen_mrs_q <= 1'b0;
			cs_prev_q <= 1'b1;
		end else begin
			cs_prev_q <= cs_n_q;
			since_mrs_q <= mrs_start ? 16'h0001 : ((since_mrs_q == 16'hFFFF) ? since_mrs_q : since_mrs_q + 16'h0001);
			seen_mrs_q <= seen_mrs_q | mrs_start;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_MRD_SPACING: assert property (mrs_start && seen_mrs_q |-> since_mrs_q >= 16'(MRD_CLK))
		else $error("register writes closer than tmrd");
	AST_MOD_GAP: assert property ($fell(cs_n_q) && !mrs_on_pins && seen_mrs_q |-> since_mrs_q >= 16'(MOD_CLK))
		else $error("command issued inside tmod");
	AST_ODT_BEFORE: assert property (fire_mrs && req_q.odt_change |-> !odt_q && odt_low_q >= ODT_HOLD)
		else $error("odt not held low before write");
	AST_ODT_HELD: assert property (fire_mrs && req_q.odt_change |=> !odt_q [*8])
		else $error("odt rose right after write");
	AST_ODT_UNTIL_MOD: assert property (odt_keep_q && !mod_ok |-> !odt_q)
		else $error("odt high before tmod expired");
	AST_RSVD_BITS: assert property (mrs_start |-> !ca_q.bg[1] && !ca_q.addr[RSVD_ADDR_BIT])
		else $error("reserved bits not zero");
	AST_NO_SEL7: assert property (mrs_start |-> {ca_q.bg[0], ca_q.ba} != SEL_RSVD)
		else $error("reserved select sent");
	AST_IDLE_ONLY: assert property (mrs_start |-> $past(idle_ok) && cke_q)
		else $error("register write outside idle");
	AST_CS_PULSE: assert property ($fell(cs_n_q) |=> !cs_n_q ##1 cs_n_q)
		else $error("chip select pulse not one ck");
	AST_WAIT_FN: assert property (st_q == ST_WAITFN && !func_done |=> cs_n_q || $past(!cs_n_q))
		else $error("command during long update");
	AST_BAD_REFUSED: assert property (take_req && req_bad |=> req_err && st_q == ST_IDLE)
		else $error("reserved request not refused");

	COV_MRS: cover property (mrs_start);
	COV_BACK_TO_BACK: cover property (mrs_start ##[1:80] mrs_start);
	COV_ODT_WRITE: cover property (fire_mrs && req_q.odt_change);
	COV_REFUSE: cover property (req_err);

endmodule : mrs_ctrl

/* File: pkg/mrs_pkg.sv */
package mrs_pkg;

	// ----------------------------------------
	// clocking and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int CK_DIV = 2;
	localparam int CK_PERIOD_NS = CLK_PERIOD_NS * CK_DIV;
	localparam int TMRD_NCK = 8;
	localparam int TMOD_NCK = 24;
	localparam int ODT_OFF_LAT = 9;
	localparam int MIN_WRITE_RECOVERY = 10;
	localparam int CNT_W = 8;
	localparam int ADDR_W = 18;

	// ----------------------------------------
	// register select and field layout
	// ----------------------------------------
	localparam logic [2:0] SEL_MR0 = 3'h0;
	localparam logic [2:0] SEL_RSVD = 3'h7;
	localparam int BL_LSB = 0;
	localparam int CL_B0 = 2;
	localparam int BT_BIT = 3;
	localparam int CL_B1 = 4;
	localparam int TM_BIT = 7;
	localparam int DLL_RST_BIT = 8;
	localparam int WR_LSB = 9;
	localparam int CL_B4 = 12;
	localparam int WR_MSB_BIT = 13;
	localparam int RSVD_ADDR_BIT = 17;
	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_OTF = 2'h1;
	localparam logic [1:0] BL_CHOP4 = 2'h2;
	localparam logic [1:0] BL_RSVD = 2'h3;
	localparam logic [3:0] WR_MAX_CODE = 4'h8;
	localparam logic [4:0] WR_BASE = 5'h0A;
	localparam logic [3:0] RTP_BASE = 4'h5;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HOLD = 2'b01,
		ST_WAITFN = 2'b11
	} state_type;

	typedef struct packed {
		logic [2:0] sel;
		logic [ADDR_W-1:0] addr;
		logic odt_change;
		logic long_update;
	} mrs_req_type;

	typedef struct packed {
		logic act_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [1:0] bg;
		logic [1:0] ba;
		logic [ADDR_W-1:0] addr;
	} ca_bus_type;

	typedef struct packed {
		logic [4:0] write_recovery;
		logic [3:0] read_to_precharge;
		logic [5:0] cas_latency;
		logic interleave;
		logic [1:0] burst_mode;
		logic dll_reset;
		logic test_mode_select;
		logic reserved_field;
	} mr0_status_type;

endpackage : mrs_pkg

/* File: sim/mode_dev_model.sv */
`timescale 1ns/100ps
module mode_dev_model
	import mrs_pkg::*;
#(
	parameter int TMRD = 8,
	parameter int TMOD = 24,
	parameter int OFFL = 9
) (
	input wire logic ck_t,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic odt,
	input wire mrs_pkg::ca_bus_type ca,
	input wire logic guard
);
	// ----------------------------------------
	// mode register device
	// ----------------------------------------
	logic [17:0] regs [0:6];
	int mrs_count = 0;
	int cmd_count = 0;
	int faults = 0;
	int since = 1000;
	int odt_low = 1000;
	logic guarded = 1'b0;
	wire is_mrs = !cs_n && ca.act_n && !ca.ras_n && !ca.cas_n && !ca.we_n;
	wire [2:0] sel = {ca.bg[0], ca.ba};
	wire [3:0] wr = {ca.addr[13], ca.addr[11:9]};
	wire [4:0] cl = {ca.addr[12], ca.addr[6:4], ca.addr[2]};
	always @(posedge ck_t) begin
		since = since + 1;
		odt_low = odt ? 0 : odt_low + 1;
		if (guarded && since < TMOD && odt) faults++;
		if (cke && !cs_n && !is_mrs) begin
			if (since < TMOD) faults++;
			cmd_count++;
		end
		if (cke && is_mrs) begin
			if (since < TMRD) faults++;
			if (guard && odt_low < OFFL + 1) faults++;
			if (ca.bg[1] || ca.addr[17]) faults++;
			if (sel == 0 && (wr > 8 || ca.addr[1:0] == 3 || cl == 20 || cl == 22 || cl >= 24))
				faults++;
			if (sel != 7) regs[sel] = ca.addr;
			else faults++;
			mrs_count++;
			guarded = guard;
			since = 0;
		end
	end
endmodule : mode_dev_model

/* File: sim/test_ddr4_mode_register_programming.sv */
`timescale 1ns/100ps
module test_ddr4_mode_register_programming;
	import mrs_pkg::*;
	// ----------------------------------------
	// bench
	// ----------------------------------------
	logic clk = 0;
	logic rst_n = 0;
	logic req_valid = 0;
	mrs_req_type req = '0;
	logic cmd_valid = 0;
	ca_bus_type cmd = '0;
	logic idle_ok = 1;
	logic odt_want = 0;
	logic func_done = 0;
	logic guard = 0;
	logic req_ready, req_err, cmd_ready, busy, ck_t, ck_c, cke, odt, cs_n;
	mr0_status_type mr0_status;
	ca_bus_type ca;
	int mismatches = 0;
	int checks = 0;
	int cl_tab [0:24] = '{9, 10, 11, 12, 13, 14, 15, 16, 18, 20, 22, 24, 23, 17, 19, 21, 25,
		26, 27, 28, 0, 30, 0, 32, 0};
	logic [20:0] bad_tab [0:3] = '{21'h1C0000, 21'h002200, 21'h000003, 21'h001020};
	always #5 clk = ~clk;
	mrs_ctrl mrs_ctrl_i (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .req_err(req_err), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .idle_ok(idle_ok), .odt_want(odt_want), .func_done(func_done),
		.busy(busy), .mr0_status(mr0_status), .ck_t(ck_t), .ck_c(ck_c), .cke(cke), .odt(odt),
		.cs_n(cs_n), .ca(ca));
	mode_dev_model mode_dev_model_i (.ck_t(ck_t), .cke(cke), .cs_n(cs_n), .odt(odt), .ca(ca),
		.guard(guard));
	task test_done();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	task bail();
		mismatches++;
		$display("mismatch %0t wait ran out", $time);
		test_done();
	endtask : bail
	task cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask : cmp_val
	function automatic logic [19:0] pk(input mr0_status_type s);
		return {s.write_recovery, s.read_to_precharge, s.cas_latency, s.interleave,
			s.burst_mode, s.dll_reset, s.test_mode_select};
	endfunction : pk
	function automatic logic [19:0] ex(input logic [17:0] a);
		int w;
		int c;
		w = {a[13], a[11:9]};
		c = {a[12], a[6:4], a[2]};
		return {5'(10 + 2 * w), 4'(5 + w), 6'(cl_tab[c]), a[3], a[1:0], a[8], a[7]};
	endfunction : ex
	function automatic logic [17:0] gen();
		logic [17:0] a;
		logic [3:0] w;
		logic [4:0] c;
		a = 18'($urandom);
		w = 4'($urandom_range(8, 0));
		c = 5'd20;
		while (c == 20 || c == 22)
			c = 5'($urandom_range(23, 0));
		{a[13], a[11:9]} = w;
		{a[12], a[6:4], a[2]} = c;
		a[1:0] = 2'($urandom_range(2, 0));
		return a;
	endfunction : gen
	task send(input logic [2:0] s, input logic [17:0] a, input logic lu, input logic bad,
		input logic gate);
		int n0;
		int i;
		int e;
		n0 = mode_dev_model_i.mrs_count;
		@(posedge clk);
		req_valid <= 1;
		req <= '{s, a, guard, lu};
		i = 0;
		@(negedge clk);
		while (req_ready !== 1'b1) begin
			if (++i > 300) bail();
			@(negedge clk);
		end
		@(posedge clk);
		req_valid <= 0;
		e = 0;
		repeat (3) begin
			@(negedge clk);
			if (req_err === 1'b1) e++;
		end
		cmp_val(e, bad, "refusal pulse");
		if (gate) begin
			repeat (30) @(negedge clk);
			cmp_val(mode_dev_model_i.mrs_count, n0, "issued while busy");
			@(posedge clk);
			idle_ok <= 1;
		end
		i = 0;
		while (!bad && mode_dev_model_i.mrs_count == n0) begin
			if (++i > 400) bail();
			@(negedge clk);
		end
		if (bad) cmp_val(mode_dev_model_i.mrs_count, n0, "refused reached pins");
	endtask : send
	task send_cmd();
		int i;
		@(posedge clk);
		cmd_valid <= 1;
		cmd <= '{1'b0, 1'b1, 1'b1, 1'b1, 2'h0, 2'h1, 18'h00010};
		i = 0;
		@(negedge clk);
		while (cmd_ready !== 1'b1) begin
			if (++i > 300) bail();
			@(negedge clk);
		end
		@(posedge clk);
		cmd_valid <= 0;
		repeat (4) @(negedge clk);
	endtask : send_cmd
	initial begin
		#3000000;
		bail();
	end
	initial begin
		int k;
		int e;
		logic [17:0] w;
		logic [17:0] last0;
		void'($urandom(59862));
		repeat (12) @(posedge clk);
		rst_n <= 1;
		for (k = 0; k < 8; k++) begin
			w = (k == 0) ? 18'h0 : gen();
			send(3'h0, w, 0, 0, 0);
			last0 = w;
			cmp_val(pk(mr0_status), ex(w), "decode");
			cmp_val(mode_dev_model_i.regs[0], {1'b0, w[16:0]}, "pin word");
		end
		for (k = 1; k < 7; k++) begin
			w = gen();
			send(3'(k), w, 0, 0, 0);
			cmp_val(mode_dev_model_i.regs[k], {1'b0, w[16:0]}, "other reg");
		end
		for (k = 0; k < 4; k++) begin
			send(bad_tab[k][20:18], bad_tab[k][17:0], 0, 1, 0);
			cmp_val(pk(mr0_status), ex(last0), "status kept");
		end
		e = mode_dev_model_i.cmd_count;
		send(3'h2, gen(), 0, 0, 0);
		send_cmd();
		cmp_val(mode_dev_model_i.cmd_count, e + 1, "command passed");
		@(posedge clk);
		idle_ok <= 0;
		send(3'h4, gen(), 0, 0, 1);
		@(posedge clk);
		odt_want <= 1;
		guard <= 1;
		repeat (20) @(negedge clk);
		send(3'h1, gen(), 0, 0, 0);
		repeat (60) @(negedge clk);
		cmp_val(odt, 1, "odt back high");
		@(posedge clk);
		odt_want <= 0;
		guard <= 0;
		send(3'h3, gen(), 1, 0, 0);
		e = 0;
		repeat (40) begin
			@(negedge clk);
			if (req_ready !== 1'b0) e++;
		end
		cmp_val(e, 0, "long update hold");
		@(posedge clk);
		func_done <= 1;
		@(posedge clk);
		func_done <= 0;
		send(3'h5, gen(), 0, 0, 0);
		cmp_val(mode_dev_model_i.faults, 0, "device faults");
		test_done();
	end
endmodule : test_ddr4_mode_register_programming
